// [src/pulse_trigger_source_select.sv]
// trigger source selection and software force for a bank of pulse generators
// register map, per generator g, indices step by 100 between generators:
//   source select  601006 + 100g  bits 3:0 code of the second selector
//   configuration  601007 + 100g  bit 0 inverts the first selector level
//                                 bit 1 inverts the second selector level
//                                 bit 2 inverts the generator output
//                                 bit 3 level sensing instead of edge
//   first select   601000 + 100g  bit 0 enables the first selector level
//                                 bits 3:1 read only: synced line, gate, start
//   command        601501         write only, reads back zero
//
// source codes of the second selector:
//   0 static high, 1 software force edge, 2 card trigger,
//   3..6 cascade from generator zero..three, 7..10 line zero..three,
//   11..15 reserved, they give a low second level, so a stray code fires only when bit 1 inverts it
//
// limitations:
//   - a generator cascading from its own output is not blocked here,
//     software has to keep each generator off its own cascade code
//   - line codes for lines that a card variant lacks or only drives
//     are not blocked either, they pass whatever the pin shows
//   - a line change reaches the gate two clocks late and the start one
//     clock after that, the price paid for a safe synchroniser
//   - the force pulse is one clock wide, but force writes on back-to-back clocks
//     merge into one pulse, so an edge-sensing generator sees one rising edge for both
//   - the gate itself is combinational, the start is registered
`timescale 1ns/100ps
module pulse_trigger_source_select
  import trig_src_pkg::*;
#(
  parameter int GENS = 4
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [31:0]       reg_rdata,
  // external multi-purpose lines, asynchronous
  input  wire logic [3:0]        multi_line_in,
  // first selector levels and card trigger
  input  wire logic [GENS-1:0]   first_sel_level,
  input  wire logic              card_trigger,
  // generator outputs fed back for cascading
  input  wire logic [3:0]        gen_pulse_out,
  // results toward the pulse timing stage
  output logic [GENS-1:0]        trig_gate,
  output logic [GENS-1:0]        gen_start,
  output logic [GENS-1:0]        out_invert,
  output logic                   soft_edge_q
);
  logic [3:0]      line_meta_q;
  logic [3:0]      line_sync_q;
  logic [3:0]      second_src_q [GENS];
  logic [3:0]      config_q     [GENS];
  logic [GENS-1:0] first_en_q;
  logic [GENS-1:0] hit_src;
  logic [GENS-1:0] hit_cfg;
  logic [GENS-1:0] hit_first;
  logic            hit_cmd;

  // index of a per-generator register
  function automatic logic [ADDR_W-1:0] gen_idx(input logic [ADDR_W-1:0] base, input int g);
    gen_idx = base + ADDR_W'(g) * GEN_STRIDE_IDX;
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // one hit vector per register kind, shared by the write and read sides
  always_comb begin
    for (int g = 0; g < GENS; g++) begin
      hit_src[g]   = (reg_addr == gen_idx(SRC_SELECT_BASE_IDX, g));
      hit_cfg[g]   = (reg_addr == gen_idx(CONFIG_BASE_IDX, g));
      hit_first[g] = (reg_addr == gen_idx(FIRST_SEL_BASE_IDX, g));
    end
  end

  // the command register sits outside the per-generator stride
  assign hit_cmd = (reg_addr == PULSE_COMMAND_IDX);

  // ----------------------------------------------------------------
  // line synchroniser
  // ----------------------------------------------------------------
  // first stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      line_meta_q <= 4'h0;
      line_sync_q <= 4'h0;
    end else begin
      line_meta_q <= multi_line_in;
      line_sync_q <= line_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  // one write gives one pulse; other codes are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      soft_edge_q <= 1'b0;
    end else begin
      soft_edge_q <= reg_write && hit_cmd
                     && reg_wdata == FORCE_TRIGGER_CMD;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // source select codes; reserved codes are kept as written and give a low second level
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int g = 0; g < GENS; g++) begin
        second_src_q[g] <= SRC_SELECT_RESET;
      end
    end else if (reg_write) begin
      for (int g = 0; g < GENS; g++) begin
        if (hit_src[g]) begin
          second_src_q[g] <= reg_wdata[3:0];
        end
      end
    end
  end

  // inverter and sensing bits
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int g = 0; g < GENS; g++) begin
        config_q[g] <= CONFIG_RESET;
      end
    end else if (reg_write) begin
      for (int g = 0; g < GENS; g++) begin
        if (hit_cfg[g]) begin
          config_q[g] <= reg_wdata[3:0];  // any combination allowed
        end
      end
    end
  end

  // first selector enables; reset to pass so the first selector level reaches the gate
  always_ff @(posedge clk) begin
    if (reset) begin
      first_en_q <= {GENS{FIRST_EN_RESET}};
    end else if (reg_write) begin
      for (int g = 0; g < GENS; g++) begin
        if (hit_first[g]) begin
          first_en_q[g] <= reg_wdata[0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // command register reads zero; unmapped reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      reg_rdata <= 32'h0;
      for (int g = 0; g < GENS; g++) begin
        if (hit_src[g]) begin
          reg_rdata <= {28'h0, second_src_q[g]};
        end
        if (hit_cfg[g]) begin
          reg_rdata <= {28'h0, config_q[g]};
        end
        if (hit_first[g]) begin
          reg_rdata <= {28'h0, gen_start[g], trig_gate[g], line_sync_q[g], first_en_q[g]};
        end
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // per-generator trigger stages
  // ----------------------------------------------------------------
  // the single force pulse fans out to all units on the same edge
  for (genvar g = 0; g < GENS; g++) begin : gen_unit
    trig_gen_unit u_unit (
      .clk          (clk),
      .reset        (reset),
      .second_src   (second_src_q[g]),
      .config_bits  (config_q[g]),
      .first_level  (first_sel_level[g] & first_en_q[g]),
      .soft_edge    (soft_edge_q),
      .card_trigger (card_trigger),
      .gen_out      (gen_pulse_out),
      .line_sync    (line_sync_q),
      .trig_gate    (trig_gate[g]),
      .start_q      (gen_start[g])
    );
    assign out_invert[g] = config_q[g][CFG_OUT_INV_BIT];
  end
endmodule // pulse_trigger_source_select

// [src/trig_src_pkg.sv]
// constants for the pulse generator trigger source path
package trig_src_pkg;
  // register indices (byte address is index times four, on the plain port only the index matters)
  localparam logic [19:0] PULSE_COMMAND_IDX  = 20'd601501;
  localparam logic [19:0] SRC_SELECT_BASE_IDX = 20'd601006;
  localparam logic [19:0] CONFIG_BASE_IDX    = 20'd601007;
  localparam logic [19:0] FIRST_SEL_BASE_IDX  = 20'd601000;
  localparam logic [19:0] GEN_STRIDE_IDX     = 20'd100;
  localparam int          ADDR_W             = 20;

  // command codes
  localparam logic [31:0] FORCE_TRIGGER_CMD  = 32'h0000_0001;

  // second selector source codes
  localparam logic [3:0] SRC_UNUSED          = 4'h0;
  localparam logic [3:0] SRC_SOFTWARE_EDGE   = 4'h1;
  localparam logic [3:0] SRC_CARD_TRIGGER    = 4'h2;
  localparam logic [3:0] SRC_FROM_GEN_ZERO   = 4'h3;
  localparam logic [3:0] SRC_FROM_GEN_ONE    = 4'h4;
  localparam logic [3:0] SRC_FROM_GEN_TWO    = 4'h5;
  localparam logic [3:0] SRC_FROM_GEN_THREE  = 4'h6;
  localparam logic [3:0] SRC_FROM_LINE_ZERO  = 4'h7;
  localparam logic [3:0] SRC_FROM_LINE_ONE   = 4'h8;
  localparam logic [3:0] SRC_FROM_LINE_TWO   = 4'h9;
  localparam logic [3:0] SRC_FROM_LINE_THREE = 4'ha;

  // configuration bit positions
  localparam int CFG_FIRST_INV_BIT  = 0;
  localparam int CFG_SECOND_INV_BIT = 1;
  localparam int CFG_OUT_INV_BIT    = 2;
  localparam int CFG_HIGH_BIT       = 3;

  // reset values
  localparam logic [3:0] SRC_SELECT_RESET = 4'h0;
  localparam logic [3:0] CONFIG_RESET     = 4'h0;
  localparam logic       FIRST_EN_RESET   = 1'b1;
endpackage

// [src/trig_gen_unit.sv]
// trigger conditioning for one pulse generator
`timescale 1ns/100ps
module trig_gen_unit
  import trig_src_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // configuration
  input  wire logic [3:0] second_src,
  input  wire logic [3:0] config_bits,
  input  wire logic       first_level,
  // candidate sources
  input  wire logic       soft_edge,
  input  wire logic       card_trigger,
  input  wire logic [3:0] gen_out,
  input  wire logic [3:0] line_sync,
  // result
  output logic            trig_gate,
  output logic            start_q
);
  logic second_raw;
  logic prev_q;

  // --------------------------------------------------------------
  // second selector, inverters and combination
  // --------------------------------------------------------------
  always_comb begin
    unique case (second_src)
      SRC_UNUSED:          second_raw = 1'b1;          // transparent to and
      SRC_SOFTWARE_EDGE:   second_raw = soft_edge;
      SRC_CARD_TRIGGER:    second_raw = card_trigger;
      SRC_FROM_GEN_ZERO:   second_raw = gen_out[0];
      SRC_FROM_GEN_ONE:    second_raw = gen_out[1];
      SRC_FROM_GEN_TWO:    second_raw = gen_out[2];
      SRC_FROM_GEN_THREE:  second_raw = gen_out[3];
      SRC_FROM_LINE_ZERO:  second_raw = line_sync[0];
      SRC_FROM_LINE_ONE:   second_raw = line_sync[1];
      SRC_FROM_LINE_TWO:   second_raw = line_sync[2];
      SRC_FROM_LINE_THREE: second_raw = line_sync[3];
      default:             second_raw = 1'b0;          // reserved codes give low, high only through the second inverter
    endcase
  end

  // both selector outputs pass their own inverter, the gate is always active high
  assign trig_gate = (first_level ^ config_bits[CFG_FIRST_INV_BIT])
                   & (second_raw ^ config_bits[CFG_SECOND_INV_BIT]);

  // --------------------------------------------------------------
  // edge or level sensing
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_q  <= 1'b1;  // a gate already high at reset is not an edge
      start_q <= 1'b0;
    end else begin
      prev_q  <= trig_gate;
      start_q <= config_bits[CFG_HIGH_BIT] ? trig_gate : (trig_gate & ~prev_q);
    end
  end
endmodule // trig_gen_unit

// [verification/pulse_trigger_source_select_chk.sv]
// port checks for the trigger source select block
`timescale 1ns/100ps
module pulse_trigger_source_select_chk
  import trig_src_pkg::*;
#(parameter int GENS = 4) (
  // watched ports
  input wire logic              clk, reset, reg_write, reg_read, soft_edge_q,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata, reg_rdata,
  input wire logic [GENS-1:0]   trig_gate, gen_start, out_invert
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a force write as the port sees it
  wire cmd_force = reg_write && reg_addr == PULSE_COMMAND_IDX && reg_wdata == FORCE_TRIGGER_CMD;
  chk_force_edge: assert property (cmd_force |=> soft_edge_q) else $error("no force edge");
  chk_force_cause: assert property (soft_edge_q |-> $past(cmd_force)) else $error("stray force edge");
  chk_cmd_wo: assert property (reg_read && reg_addr == PULSE_COMMAND_IDX |=> reg_rdata == 32'h0)
    else $error("command read not zero");
  chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0) else $error("stray read data");
  // the guard skips the edge right after reset, where the detector still holds its reset state
  chk_rise_start: assert property ($rose(trig_gate[0]) && !$past(reset) |=> gen_start[0])
    else $error("missed start");
  chk_start_gate: assert property ((gen_start & ~$past(trig_gate)) == '0) else $error("start w/o gate");
  chk_out_inv: assert property (reg_write && reg_addr == CONFIG_BASE_IDX |=> out_invert[0] == $past(reg_wdata[2]))
    else $error("output invert wrong");
  chk_reset_vals: assert property ($past(reset) |-> !soft_edge_q && gen_start == '0)
    else $error("outputs not at reset value");
endmodule // pulse_trigger_source_select_chk

// [verification/ext_line_model.sv]
// external multi-purpose line source
`timescale 1ns/100ps
module ext_line_model (
  // clock and wanted levels
  input  wire logic       clk,
  input  wire logic [3:0] level,
  // line drive
  output logic      [3:0] line
);
  // another box drives the lines, so they move well away from our edge
  initial line = 4'h0;
  always @(posedge clk) line <= #13 level;
endmodule // ext_line_model

// [verification/pulse_trigger_source_select_tb_top.sv]
// self-checking bench for the trigger source select block
`timescale 1ns/100ps
module pulse_trigger_source_select_tb_top;
  import trig_src_pkg::*;
  logic              clk, reset, reg_write, reg_read, card_trigger, soft_edge_q;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  logic [3:0]        line_want, multi_line_in, first_sel_level, gen_pulse_out, trig_gate, gen_start, out_invert;
  int                fails, samples_checked;
  typedef struct packed {logic [3:0] src, lines, gpo, cfg; logic gate;} row_s;
  // source, lines, cascade, config, gate of generator zero; never its own output
  row_s rows [15] = '{'{4'h0, 4'h0, 4'h0, 4'h4, 1'b1}, '{4'h0, 4'h0, 4'h0, 4'h1, 1'b0},
    '{4'h5, 4'h0, 4'h4, 4'h0, 1'b1}, '{4'h5, 4'hf, 4'hb, 4'h0, 1'b0}, '{4'h6, 4'h0, 4'h8, 4'h0, 1'b1},
    '{4'h6, 4'hf, 4'h7, 4'h0, 1'b0}, '{4'h7, 4'h1, 4'h0, 4'h0, 1'b1}, '{4'h7, 4'he, 4'hf, 4'h0, 1'b0},
    '{4'h8, 4'h2, 4'h0, 4'h0, 1'b1}, '{4'h8, 4'h2, 4'h0, 4'h2, 1'b0}, '{4'h9, 4'h4, 4'h0, 4'h0, 1'b1},
    '{4'ha, 4'h8, 4'h0, 4'h0, 1'b1}, '{4'ha, 4'h7, 4'hf, 4'h2, 1'b1}, '{4'h4, 4'h0, 4'h2, 4'h0, 1'b1},
    '{4'hb, 4'hf, 4'hf, 4'h0, 1'b0}}; // all lines are inputs here
  pulse_trigger_source_select #(.GENS(4)) u_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .multi_line_in, .first_sel_level, .card_trigger, .gen_pulse_out, .trig_gate, .gen_start,
    .out_invert, .soft_edge_q);
  ext_line_model u_lines (.clk, .level(line_want), .line(multi_line_in));
  task automatic check(string name, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check("rdata", reg_rdata, exp);
  endtask
  task automatic stop_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // clock and watchdog; a hang counts as a mismatch
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial begin
    reset = 1'b1;
    {reg_write, reg_read, card_trigger, reg_addr, reg_wdata} = '0;
    {line_want, gen_pulse_out, first_sel_level} = 12'h00f;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(SRC_SELECT_BASE_IDX, 32'h0);
    rd(CONFIG_BASE_IDX, 32'h0);
    // table rows; five edges cover the model skew plus the two synchroniser stages
    foreach (rows[i]) begin
      wr(SRC_SELECT_BASE_IDX, {28'h0, rows[i].src});
      wr(CONFIG_BASE_IDX, {28'h0, rows[i].cfg});
      line_want <= rows[i].lines;
      gen_pulse_out <= rows[i].gpo;
      repeat (5) @(posedge clk);
      #1 check("gate", trig_gate[0], rows[i].gate);
      check("out_inv", out_invert[0], rows[i].cfg[2]);
    end
    // all generators on the software edge
    for (int g = 0; g < 4; g++) begin
      wr(SRC_SELECT_BASE_IDX + GEN_STRIDE_IDX * 20'(g), {28'h0, SRC_SOFTWARE_EDGE});
      wr(CONFIG_BASE_IDX + GEN_STRIDE_IDX * 20'(g), 32'h0);
    end
    wr(PULSE_COMMAND_IDX, 32'h2);
    #1 check("soft_ignored", soft_edge_q, 1'b0);
    check("gate_idle", trig_gate, 4'h0);
    wr(PULSE_COMMAND_IDX, FORCE_TRIGGER_CMD);
    #1 check("soft", soft_edge_q, 1'b1);
    check("gate_all", trig_gate, 4'hf);
    @(posedge clk);
    #1 check("start_all", gen_start, 4'hf);
    check("soft_once", soft_edge_q, 1'b0);
    // static high gate: edge mode starts once, level mode keeps starting
    wr(SRC_SELECT_BASE_IDX + 20'd200, 32'h0);
    wr(SRC_SELECT_BASE_IDX + 20'd300, 32'h0);
    wr(CONFIG_BASE_IDX + 20'd300, 32'h8);
    repeat (3) @(posedge clk);
    #1 check("start_level", gen_start, 4'h8);
    wr(CONFIG_BASE_IDX + 20'd100, 32'h7);
    rd(CONFIG_BASE_IDX + 20'd100, 32'h7);
    rd(PULSE_COMMAND_IDX, 32'h0);
    rd(20'd600000, 32'h0);
    // card trigger on generator two: one start per rising edge
    wr(SRC_SELECT_BASE_IDX + 20'd200, {28'h0, SRC_CARD_TRIGGER});
    @(posedge clk);
    card_trigger <= 1'b1;
    @(posedge clk);
    #1 check("start_card", gen_start[2], 1'b1);
    check("gate_card", trig_gate[2], 1'b1);
    @(posedge clk);
    #1 check("start_once", gen_start[2], 1'b0);
    // falling edge of line one on generator zero through the second inverter
    wr(CONFIG_BASE_IDX, 32'h2);
    wr(SRC_SELECT_BASE_IDX, {28'h0, SRC_FROM_LINE_ONE});
    line_want <= 4'h5;
    repeat (2) @(posedge clk);
    #1 check("sync_hold", trig_gate[0], 1'b0);
    repeat (2) @(posedge clk);
    #1 check("start_fall", gen_start[0], 1'b1);
    stop_test();
  end
endmodule // pulse_trigger_source_select_tb_top

bind pulse_trigger_source_select pulse_trigger_source_select_chk #(.GENS(GENS)) u_chk (.clk, .reset, .reg_write,
  .reg_read, .soft_edge_q, .reg_addr, .reg_wdata, .reg_rdata, .trig_gate, .gen_start, .out_invert);
